// file: src/tsc_cfg_top.v
/*
  Configuration register of a two-wire temperature sensor: a two-wire
  slave that writes and reads the register, a conversion timebase with
  shutdown and one-shot control, and the fault queue behind the alert pin.
  Assumes the nonvolatile register logic sits on the same clock and drives
  the stored fields, lock bits and busy flag; the bus pins and the address
  straps come from outside and are synchronised here.
*/
`timescale 1ns/100ps
`include "tsc_cfg_regs.vh"

module tsc_cfg_top #(
  parameter CONV9_CYC  = `TSC_T_CONV9_MS  * `TSC_CLK_KHZ,
  parameter CONV10_CYC = `TSC_T_CONV10_MS * `TSC_CLK_KHZ,
  parameter CONV11_CYC = `TSC_T_CONV11_MS * `TSC_CLK_KHZ,
  parameter CONV12_CYC = `TSC_T_CONV12_MS * `TSC_CLK_KHZ
) (
  input  wire       i_sys_clk,
  input  wire       i_rstn,
  input  wire       i_scl,
  input  wire       i_sda,
  output wire       o_sda_out,
  output reg        o_sda_oe,
  input  wire [2:0] i_strapped_address_bits,
  input  wire [1:0] i_stored_resolution,
  input  wire [1:0] i_stored_fault_queue,
  input  wire       i_stored_polarity,
  input  wire       i_stored_thermostat_mode,
  input  wire       i_stored_shutdown,
  input  wire       i_register_lock,
  input  wire       i_permanent_lockdown,
  input  wire       i_nv_busy_flag,
  input  wire       i_copy_nv_to_vol,
  input  wire       i_copy_vol_to_nv,
  input  wire       i_temp_fault,
  output reg        o_copy_to_nv,
  output reg        o_temp_update,
  output reg        o_conv_active,
  output reg        o_alert,
  output wire [7:0] o_config
);

  localparam ST_IDLE = 3'h0;
  localparam ST_RX   = 3'h1;
  localparam ST_ACK  = 3'h2;
  localparam ST_TX   = 3'h3;
  localparam ST_MACK = 3'h4;

  reg       scl_s1_q, scl_s2_q, scl_d_q;
  reg       sda_s1_q, sda_s2_q, sda_d_q;
  reg [2:0] adr_s1_q, adr_s2_q;
  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [1:0] byte_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] ptr_q;
  reg       read_q;
  reg       rd_byte_q;
  reg       loaded_q;
  reg       one_shot_q;
  reg [1:0] res_q;
  reg [1:0] fq_q;
  reg       pol_q;
  reg       mode_q;
  reg       sd_q;
  reg       running_q;
  reg [21:0] conv_cnt_q;
  reg [2:0] fault_cnt_q;
  reg       alert_act_q;

  wire scl_rise = scl_s2_q & ~scl_d_q;
  wire scl_fall = ~scl_s2_q & scl_d_q;
  wire start_c  = scl_s2_q & scl_d_q & sda_d_q & ~sda_s2_q;
  wire stop_c   = scl_s2_q & scl_d_q & ~sda_d_q & sda_s2_q;
  wire locked   = i_register_lock | i_permanent_lockdown;
  wire addr_hit = (shift_q[7:1] == {`TSC_ADDR_HI, adr_s2_q});
  wire cfg_wr   = (state_q == ST_RX) && scl_fall && (bit_cnt_q == 4'h8)
                  && (byte_cnt_q == 2'h2) && !read_q
                  && (ptr_q == `TSC_PTR_CONFIG);
  wire wr_ok    = cfg_wr && !locked;
  wire conv_end = running_q && (conv_cnt_q == 22'h000000);

  wire [7:0] cfg_hi = {1'b0, res_q, fq_q, pol_q, mode_q, sd_q};
  wire [7:0] cfg_lo = {7'h00, i_nv_busy_flag};
  wire [7:0] tx_byte = rd_byte_q ? cfg_lo : cfg_hi;

  assign o_sda_out = 1'b0;
  assign o_config  = {one_shot_q, res_q, fq_q, pol_q, mode_q, sd_q};

  reg [21:0] conv_len;
  reg [2:0]  fq_need;
  always @* begin
    case (res_q)
      2'h0:    conv_len = CONV9_CYC[21:0]  - 22'h1;
      2'h1:    conv_len = CONV10_CYC[21:0] - 22'h1;
      2'h2:    conv_len = CONV11_CYC[21:0] - 22'h1;
      default: conv_len = CONV12_CYC[21:0] - 22'h1;
    endcase
    case (fq_q)
      2'h0:    fq_need = 3'h1;
      2'h1:    fq_need = 3'h2;
      2'h2:    fq_need = 3'h4;
      default: fq_need = 3'h6;
    endcase
  end

  // Only the second stage of each synchroniser, and for the bus lines its delayed copy, feeds any logic.
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_d_q  <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_d_q  <= 1'b1;
      adr_s1_q <= 3'h0;
      adr_s2_q <= 3'h0;
    end else begin
      scl_s1_q <= i_scl;
      scl_s2_q <= scl_s1_q;
      scl_d_q  <= scl_s2_q;
      sda_s1_q <= i_sda;
      sda_s2_q <= sda_s1_q;
      sda_d_q  <= sda_s2_q;
      adr_s1_q <= i_strapped_address_bits;
      adr_s2_q <= adr_s1_q;
    end
  end

  // Two-wire slave. A START or STOP anywhere abandons the byte in flight,
  // so a partial data byte never reaches the register.
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      byte_cnt_q <= 2'h0;
      shift_q    <= 8'h00;
      ptr_q      <= 8'h00;
      read_q     <= 1'b0;
      rd_byte_q  <= 1'b0;
      o_sda_oe   <= 1'b0;
    end else if (start_c) begin
      state_q    <= ST_RX;
      bit_cnt_q  <= 4'h0;
      byte_cnt_q <= 2'h0;
      o_sda_oe   <= 1'b0;
    end else if (stop_c) begin
      state_q  <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end else begin
      case (state_q)
        ST_RX: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s2_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            bit_cnt_q <= 4'h0;
            state_q   <= ST_ACK;
            o_sda_oe  <= 1'b1;
            if (byte_cnt_q == 2'h0) begin
              read_q <= shift_q[0];
              rd_byte_q <= 1'b0;
              if (!addr_hit) begin
                state_q  <= ST_IDLE;
                o_sda_oe <= 1'b0;
              end
            end else if (byte_cnt_q == 2'h1) begin
              ptr_q <= shift_q;
            end
            // Extra bytes are acknowledged but stored nowhere.
            if (byte_cnt_q != 2'h3) begin
              byte_cnt_q <= byte_cnt_q + 2'h1;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            if (read_q) begin
              state_q  <= ST_TX;
              o_sda_oe <= ~tx_byte[7];
              shift_q  <= {tx_byte[6:0], 1'b0};
            end else begin
              state_q  <= ST_RX;
              o_sda_oe <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == 4'h8) begin
              o_sda_oe  <= 1'b0;
              state_q   <= ST_MACK;
              bit_cnt_q <= 4'h0;
              rd_byte_q <= ~rd_byte_q;
            end else begin
              o_sda_oe <= ~shift_q[7];
              shift_q  <= {shift_q[6:0], 1'b0};
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_s2_q) begin
            state_q <= ST_IDLE;
          end else if (scl_fall) begin
            state_q  <= ST_TX;
            o_sda_oe <= ~tx_byte[7];
            shift_q  <= {tx_byte[6:0], 1'b0};
          end
        end
        default: begin
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Stored fields cannot be taken under the asynchronous reset, so the
  // first clock after release copies them in.
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      loaded_q     <= 1'b0;
      res_q        <= `TSC_RST_RES;
      fq_q         <= `TSC_RST_FQ;
      pol_q        <= `TSC_RST_POL;
      mode_q       <= `TSC_RST_MODE;
      sd_q         <= `TSC_RST_SHUTDOWN;
      one_shot_q   <= 1'b0;
      o_copy_to_nv <= 1'b0;
    end else begin
      o_copy_to_nv <= i_copy_vol_to_nv && !i_nv_busy_flag;
      if (!loaded_q || (i_copy_nv_to_vol && !i_nv_busy_flag)) begin
        loaded_q <= 1'b1;
        res_q    <= i_stored_resolution;
        fq_q     <= i_stored_fault_queue;
        pol_q    <= i_stored_polarity;
        mode_q   <= i_stored_thermostat_mode;
        sd_q     <= i_stored_shutdown;
      end else if (wr_ok) begin
        res_q  <= shift_q[`TSC_RES_HI:`TSC_RES_LO];
        fq_q   <= shift_q[`TSC_FQ_HI:`TSC_FQ_LO];
        pol_q  <= shift_q[`TSC_BIT_POLARITY];
        mode_q <= shift_q[`TSC_BIT_MODE];
        sd_q   <= shift_q[`TSC_BIT_SHUTDOWN];
      end
      // A trigger counts only when the engine already sits in shutdown.
      if (wr_ok && shift_q[`TSC_BIT_ONE_SHOT] && sd_q && !running_q
          && shift_q[`TSC_BIT_SHUTDOWN]) begin
        one_shot_q <= 1'b1;
      end else if (conv_end) begin
        one_shot_q <= 1'b0;
      end
    end
  end

  // Conversion timebase and fault queue.
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      running_q     <= 1'b0;
      conv_cnt_q    <= 22'h000000;
      o_temp_update <= 1'b0;
      o_conv_active <= 1'b0;
      fault_cnt_q   <= 3'h0;
      alert_act_q   <= 1'b0;
      o_alert       <= 1'b0;
    end else begin
      o_temp_update <= conv_end;
      if (!running_q) begin
        if (loaded_q && (!sd_q || one_shot_q)) begin
          running_q  <= 1'b1;
          conv_cnt_q <= conv_len;
        end
      end else if (conv_end) begin
        // Shutdown takes effect only at the end of a conversion.
        running_q  <= !sd_q;
        conv_cnt_q <= conv_len;
      end else begin
        conv_cnt_q <= conv_cnt_q - 22'h1;
      end
      o_conv_active <= running_q;
      if (conv_end) begin
        if (!i_temp_fault) begin
          fault_cnt_q <= 3'h0;
          if (!mode_q) begin
            alert_act_q <= 1'b0;
          end
        end else if (fault_cnt_q + 3'h1 >= fq_need) begin
          fault_cnt_q <= fq_need;
          // Interrupt mode fires once per run of faults.
          if (!mode_q || fault_cnt_q + 3'h1 == fq_need) begin
            alert_act_q <= 1'b1;
          end
        end else begin
          fault_cnt_q <= fault_cnt_q + 3'h1;
        end
      end else if (mode_q && state_q == ST_ACK && byte_cnt_q == 2'h1
                   && read_q) begin
        alert_act_q <= 1'b0;
      end
      o_alert <= pol_q ? alert_act_q : ~alert_act_q;
    end
  end

endmodule

// file: include/tsc_cfg_regs.vh
/*
  Constants for the temperature sensor configuration register block:
  bus codes, field positions, reset values and conversion times.
  Assumes it is included by its bare name from the design file.
*/
`ifndef TSC_CFG_REGS_VH
`define TSC_CFG_REGS_VH

`define TSC_ADDR_HI        4'h9
`define TSC_PTR_CONFIG     8'h01

`define TSC_BIT_ONE_SHOT   7
`define TSC_RES_HI         6
`define TSC_RES_LO         5
`define TSC_FQ_HI          4
`define TSC_FQ_LO          3
`define TSC_BIT_POLARITY   2
`define TSC_BIT_MODE       1
`define TSC_BIT_SHUTDOWN   0
`define TSC_BIT_NV_BUSY    0

`define TSC_RST_RES        2'h0
`define TSC_RST_FQ         2'h0
`define TSC_RST_POL        1'h0
`define TSC_RST_MODE       1'h0
`define TSC_RST_SHUTDOWN   1'h1

`define TSC_CLK_KHZ        20000
`define TSC_T_CONV9_MS     25
`define TSC_T_CONV10_MS    50
`define TSC_T_CONV11_MS    100
`define TSC_T_CONV12_MS    200

`endif

// file: testbench/tsc_cfg_chk.sv
/* Assertion checker for tsc_cfg_top, bound to the design module.
   Assumes one clock domain and the asynchronous active-low reset. */
`timescale 1ns/100ps
module tsc_cfg_chk (
  input wire       i_sys_clk,
  input wire       i_rstn,
  input wire       i_register_lock,
  input wire       i_permanent_lockdown,
  input wire       i_nv_busy_flag,
  input wire       i_copy_nv_to_vol,
  input wire       i_copy_vol_to_nv,
  input wire       i_temp_fault,
  input wire       o_sda_out,
  input wire       o_copy_to_nv,
  input wire       o_temp_update,
  input wire       o_conv_active,
  input wire       o_alert,
  input wire [7:0] o_config
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  a_sda_value: assert property (o_sda_out == 1'b0)
    else $error("data drive value not low");
  a_copy_blocked: assert property (
    i_copy_vol_to_nv && i_nv_busy_flag |=> !o_copy_to_nv)
    else $error("copy accepted while busy");
  a_copy_echo: assert property (
    i_copy_vol_to_nv && !i_nv_busy_flag |=> o_copy_to_nv)
    else $error("copy request lost");
  a_lock_holds: assert property (
    $past(i_rstn) && (i_register_lock || i_permanent_lockdown)
    && !i_copy_nv_to_vol |=> $stable(o_config[6:0]))
    else $error("configuration changed under lock");
  // Depth one in comparator mode makes the pin follow each result.
  a_alert_follow: assert property (
    o_temp_update && o_config[4:3] == 2'h0 && !o_config[1]
    |-> ##[1:3] (o_alert == (i_temp_fault ~^ o_config[2])))
    else $error("alert level wrong after conversion");
  a_shutdown_idle: assert property (
    $past(i_rstn, 2) ##0 (o_config[0] && !o_config[7] && !o_conv_active)[*3]
    |=> !o_conv_active)
    else $error("conversion started in shutdown");
  logic [10:0] os_cnt;
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      os_cnt <= 11'h000;
    end else if (!o_config[7]) begin
      os_cnt <= 11'h000;
    end else if (os_cnt != 11'h7ff) begin
      os_cnt <= os_cnt + 11'h001;
    end
  end
  // The longest bench conversion is 1600 cycles, so 1700 leaves margin.
  a_oneshot_clears: assert property (os_cnt < 11'h6a4)
    else $error("one-shot bit never cleared");
  a_continuous: assert property (
    o_temp_update && !o_config[0] |-> ##[1:3] o_conv_active)
    else $error("no new conversion while running");
endmodule

bind tsc_cfg_top tsc_cfg_chk u_chk (
  .i_sys_clk, .i_rstn, .i_register_lock, .i_permanent_lockdown,
  .i_nv_busy_flag, .i_copy_nv_to_vol, .i_copy_vol_to_nv, .i_temp_fault,
  .o_sda_out, .o_copy_to_nv, .o_temp_update, .o_conv_active, .o_alert,
  .o_config
);

// file: testbench/tsc_i2c_master.sv
/* Two-wire bus master model for the configuration register bench.
   Assumes an open-drain data line with a pull-up; one bit is 8 clocks. */
`timescale 1ns/100ps
module tsc_i2c_master (
  input  wire i_clk,
  input  wire i_sda_oe,
  output wire o_scl,
  output wire o_sda
);
  reg scl_q = 1'b1;
  reg low_q = 1'b0;
  assign o_scl = scl_q;
  // A released line goes to the pull-up level, never to the last value.
  assign o_sda = ~(low_q | i_sda_oe);
  task q;
    repeat (2) @(posedge i_clk);
  endtask
  task start;
    q;
    low_q <= 1'b0;
    q;
    scl_q <= 1'b1;
    q;
    low_q <= 1'b1;
    q;
    scl_q <= 1'b0;
  endtask
  task stop;
    q;
    low_q <= 1'b1;
    q;
    scl_q <= 1'b1;
    q;
    low_q <= 1'b0;
    q;
  endtask
  // Data moves mid-low so it never changes beside a clock edge.
  task xbit(input b, output r);
    q;
    low_q <= ~b;
    q;
    scl_q <= 1'b1;
    q;
    q;
    r = o_sda;
    scl_q <= 1'b0;
  endtask
  task wbyte(input [7:0] b, output ack);
    integer i;
    reg r;
    for (i = 7; i >= 0; i = i - 1)
      xbit(b[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask
  task rbyte(input last, output [7:0] b);
    integer i;
    reg r;
    for (i = 7; i >= 0; i = i - 1) begin
      xbit(1'b1, r);
      b[i] = r;
    end
    xbit(last, r);
  endtask
endmodule

// file: testbench/tsc_cfg_top_tb.sv
/* Self-checking bench for tsc_cfg_top with a two-wire master model.
   Assumes shortened conversion counts of 200, 400, 800 and 1600. */
`timescale 1ns/100ps
module tsc_cfg_top_tb;
  localparam [2:0] ADR = 3'h5;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg        lock = 1'b0;
  reg        ldown = 1'b0;
  reg        busy = 1'b0;
  reg        c_n2v = 1'b0;
  reg        c_v2n = 1'b0;
  reg        fault = 1'b0;
  reg  [2:0] strap = ADR;
  reg  [6:0] st = 7'h4f;
  reg  [3:0] a;
  reg  [7:0] hi;
  reg  [7:0] lo;
  integer    n;
  integer    k;
  integer    cyc = 0;
  integer    miscompares = 0;
  integer    samples_checked = 0;
  wire       scl, sda, oe, sda_out, c2nv, upd, act, alert;
  wire [7:0] cfg;
  tsc_i2c_master u_mst (.i_clk(clk), .i_sda_oe(oe), .o_scl(scl),
    .o_sda(sda));
  tsc_cfg_top #(.CONV9_CYC(200), .CONV10_CYC(400), .CONV11_CYC(800),
    .CONV12_CYC(1600)) u_dut (.i_sys_clk(clk), .i_rstn(rstn),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(oe),
    .i_strapped_address_bits(strap), .i_stored_resolution(st[6:5]),
    .i_stored_fault_queue(st[4:3]), .i_stored_polarity(st[2]),
    .i_stored_thermostat_mode(st[1]), .i_stored_shutdown(st[0]),
    .i_register_lock(lock), .i_permanent_lockdown(ldown),
    .i_nv_busy_flag(busy), .i_copy_nv_to_vol(c_n2v),
    .i_copy_vol_to_nv(c_v2n), .i_temp_fault(fault),
    .o_copy_to_nv(c2nv), .o_temp_update(upd), .o_conv_active(act),
    .o_alert(alert), .o_config(cfg));
  always #25 clk = ~clk;
  task chk(input [15:0] seen, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input [7:0] d);
    u_mst.start;
    u_mst.wbyte({4'h9, ADR, 1'b0}, a[3]);
    u_mst.wbyte(8'h01, a[2]);
    u_mst.wbyte(d, a[1]);
    u_mst.wbyte(~d, a[0]);
    u_mst.stop;
    repeat (4) @(posedge clk);
  endtask
  task rd;
    u_mst.start;
    u_mst.wbyte({4'h9, ADR, 1'b1}, a[3]);
    u_mst.rbyte(1'b0, hi);
    u_mst.rbyte(1'b1, lo);
    u_mst.stop;
    repeat (4) @(posedge clk);
  endtask
  task wait_upd(input integer lim);
    n = 0;
    do begin
      @(negedge clk);
      n = n + 1;
    end while (upd !== 1'b1 && n < lim);
    if (upd !== 1'b1) chk(upd, 1'b1);
  endtask
  task nxt;
    wait_upd(4000);
    repeat (3) @(negedge clk);
  endtask
  task cnt_upd(input integer cy);
    n = 0;
    repeat (cy) begin
      @(negedge clk);
      if (upd === 1'b1) n = n + 1;
    end
  endtask
  task t_write;
    chk(cfg, 8'h4f);
    wr(8'h35);
    chk(a, 4'hf);
    chk(cfg, 8'h35);
    strap <= 3'h2;
    wr(8'h00);
    chk(a[3], 1'b0);
    strap <= ADR;
    u_mst.start;
    u_mst.wbyte({4'h9, ADR, 1'b0}, a[3]);
    u_mst.wbyte(8'h01, a[2]);
    repeat (4) u_mst.xbit(1'b0, a[0]);
    u_mst.start;
    u_mst.stop;
    chk(cfg, 8'h35);
  endtask
  task t_lock;
    for (k = 0; k < 3; k = k + 1) begin
      @(posedge clk);
      lock <= (k == 0);
      ldown <= (k == 1);
      if (k < 2) wr(8'h00);
      if (k < 2) chk({a, cfg}, 12'hf35);
    end
  endtask
  task t_read;
    for (k = 1; k >= 0; k = k - 1) begin
      @(posedge clk);
      busy <= k[0];
      rd;
      chk({hi, lo}, {8'h35, 7'h00, k[0]});
    end
  endtask
  task t_oneshot;
    wr(8'hb5);
    rd;
    chk(hi, 8'h35);
    wait_upd(2000);
    repeat (4) @(negedge clk);
    chk({upd, cfg}, 9'h035);
    cnt_upd(1000);
    chk(n, 0);
    wr(8'hb4);
    chk(cfg, 8'h34);
  endtask
  task t_conv;
    for (k = 0; k < 4; k = k + 1) begin
      wr({1'b0, k[1:0], 5'h00});
      wait_upd(4000);
      wait_upd(4000);
      chk(n, 16'd200 << k);
    end
    wr(8'h61);
    cnt_upd(3400);
    chk(n, 1);
  endtask
  task t_alert;
    @(posedge clk);
    fault <= 1'b1;
    wr(8'h0c);
    nxt;
    chk(alert, 1'b0);
    nxt;
    chk(alert, 1'b1);
    @(posedge clk);
    fault <= 1'b0;
    nxt;
    chk(alert, 1'b0);
    wr(8'h02);
    nxt;
    chk(alert, 1'b1);
    @(posedge clk);
    fault <= 1'b1;
    nxt;
    chk(alert, 1'b0);
    @(posedge clk);
    fault <= 1'b0;
    nxt;
    chk(alert, 1'b0);
    rd;
    chk(alert, 1'b1);
  endtask
  task t_copy;
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge clk);
      busy <= (k == 0);
      st <= 7'h2a;
      c_n2v <= 1'b1;
      c_v2n <= 1'b1;
      @(posedge clk);
      c_n2v <= 1'b0;
      c_v2n <= 1'b0;
      @(negedge clk);
      chk({c2nv, cfg}, k ? 9'h12a : 9'h002);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // The ceiling sits well above the longest expected run.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    t_write;
    t_lock;
    t_read;
    t_oneshot;
    t_conv;
    t_alert;
    t_copy;
    print_verdict;
  end
endmodule
